// *** wse_defs.svh ***
// Purpose : constants for the group-seven wake/SMI event register block
// Assumes : byte-wide register port, 40 MHz ref_clk
// Notes   : included by the blinker, the register block and the bench; the package and interface do not include it
`ifndef WSE_DEFS_SVH
`define WSE_DEFS_SVH

// ==========================================================
// register offsets
`define WSE_OFF_IND_TWO    8'h5E
`define WSE_OFF_SCAN_CODE  8'h5F
`define WSE_OFF_PM_ONE     8'h60
`define WSE_OFF_PM_TWO     8'h61
`define WSE_OFF_SMI_STS    8'h64
`define WSE_OFF_SMI_EN     8'h66
`define WSE_OFF_WAKE_STS   8'h68
`define WSE_OFF_WAKE_EN    8'h6C

// ==========================================================
// reset values and field masks
`define WSE_RST_IND_TWO    2'h1
`define WSE_RST_BYTE       8'h00
`define WSE_MASK_PM_ONE    8'h01
`define WSE_MASK_PM_TWO    8'h1C
`define WSE_MASK_SMI       8'hBF
`define WSE_MASK_WAKE      8'h8F
`define WSE_MASK_WAKE_CLR  8'h9F
`define WSE_BIT_SLEEP      5

// ==========================================================
// timing
`define WSE_CLK_PERIOD_NS  32'h0000_0019
`define WSE_HALF_SEC_NS    32'h1DCD_6500

`endif

// *** wse_pkg.sv ***
// Purpose : shared types for the wake/SMI event register block
// Assumes : nothing beyond wse_defs.svh
// Notes   : indicator mode codes follow the control field encoding
package wse_pkg;

    // ==========================================================
    // indicator control codes
    typedef enum logic [1:0] {
        WSE_IND_OFF     = 2'b00,
        WSE_IND_HALF    = 2'b01,
        WSE_IND_QUARTER = 2'b10,
        WSE_IND_ON      = 2'b11
    } wse_ind_mode_t;

endpackage

// *** wse_blink_if.sv ***
// Purpose : carries indicator mode and light state between top and blinker
// Assumes : single clock domain
// Notes   : none
`timescale 1ns/1ps

interface wse_blink_if;
    wse_pkg::wse_ind_mode_t mode;
    logic                   light_on;

    modport ctrl  (output mode, input light_on);
    modport blink (input mode, output light_on);
endinterface

// *** wse_blinker.sv ***
// Purpose : drives the second indicator from a half-second time base
// Assumes : ref_clk runs free
// Notes   : two-second frame of four half-second phases
`timescale 1ns/1ps
`include "wse_defs.svh"

module wse_blinker #(
    parameter int unsigned HALF_SEC_CYCLES = `WSE_HALF_SEC_NS / `WSE_CLK_PERIOD_NS,
    parameter int unsigned CNT_W           = 25
) (
    // clock and reset
    input  wire logic      ref_clk,
    input  wire logic      rst_n,
    // mode in, light out
    wse_blink_if.blink     bif
);
    import wse_pkg::*;

    logic [CNT_W-1:0] cnt_reg;
    logic [1:0]       phase_reg;
    logic             tick;
    logic             light_next;

    assign tick = (cnt_reg == CNT_W'(HALF_SEC_CYCLES - 1));

    // ==========================================================
    // half-second prescaler and phase
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else if (tick) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= 2'h0;
        end else if (tick) begin
            phase_reg <= phase_reg + 2'h1;
        end
    end

    // ==========================================================
    // light selection
    always_comb begin
        light_next = 1'b0;
        case (bif.mode)
            WSE_IND_OFF:     light_next = 1'b0;
            WSE_IND_HALF:    light_next = ~phase_reg[0];
            WSE_IND_QUARTER: light_next = (phase_reg == 2'h0);
            WSE_IND_ON:      light_next = 1'b1;
            default:         light_next = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bif.light_on <= 1'b0;
        end else begin
            bif.light_on <= light_next;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    ind_forced_a: assert property (bif.mode == WSE_IND_ON |=> bif.light_on)
        else $error("indicator not on in forced-on mode");
    ind_off_a: assert property (bif.mode == WSE_IND_OFF |=> !bif.light_on)
        else $error("indicator lit in off mode");
    ind_half_a: assert property (bif.mode == WSE_IND_HALF && tick |=>
        bif.light_on == !$past(phase_reg[0]))
        else $error("half-duty blink phase wrong");
    ind_quarter_a: assert property (bif.mode == WSE_IND_QUARTER && phase_reg != 2'h0
        |=> !bif.light_on || $past(tick))
        else $error("quarter blink lit outside first phase");
    ind_blink_c: cover property (bif.mode == WSE_IND_HALF && tick);
endmodule

// *** wse_event_regs.sv ***
// Purpose : group-seven SMI/wake status and enable, power control, indicator
// Assumes : rst_n is the standby-power power-on reset; sources are level events
// Notes   : register read data appears the cycle after the read strobe
`timescale 1ns/1ps
`include "wse_defs.svh"

module wse_event_regs #(
    parameter int unsigned HALF_SEC_CYCLES = `WSE_HALF_SEC_NS / `WSE_CLK_PERIOD_NS
) (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // event sources
    input  wire logic       general_pin_34,
    input  wire logic       general_pin_35,
    input  wire logic       general_pin_36,
    input  wire logic       general_pin_37,
    input  wire logic       general_pin_62,
    input  wire logic       keyboard_port_bit_sixteen,
    // system controls
    input  wire logic       smi_master_enable,
    input  wire logic       smi_open_drain,
    input  wire logic       wake_master_enable,
    // pins and interrupt
    output logic            group_smi_output,
    output logic            group_smi_oe_n,
    output logic            wake_output_pin,
    output logic            wake_output_oe_n,
    output logic            smi_group_irq,
    output logic            second_indicator_light
);
    import wse_pkg::*;

    // ==========================================================
    // state
    wse_ind_mode_t ind_mode_reg;
    logic [7:0]    scan_code_reg;
    logic [7:0]    pm_one_reg;
    logic [7:0]    pm_two_reg;
    logic [7:0]    smi_sts_reg;
    logic [7:0]    smi_sts_next;
    logic [7:0]    smi_en_reg;
    logic [7:0]    wake_sts_reg;
    logic [7:0]    wake_sts_next;
    logic [7:0]    wake_en_reg;
    logic [7:0]    rdata_next;
    logic [7:0]    smi_set;
    logic [7:0]    wake_set;
    logic [7:0]    smi_clr;
    logic [7:0]    wake_clr;
    logic          sleep_write;
    logic          smi_group;
    logic          smi_active;
    logic          wake_active;
    logic          wr_ind;
    logic          wr_scan;
    logic          wr_pm_one;
    logic          wr_pm_two;
    logic          wr_smi_sts;
    logic          wr_smi_en;
    logic          wr_wake_sts;
    logic          wr_wake_en;

    wse_blink_if blink_if ();

    // ==========================================================
    // write decode
    assign wr_ind      = reg_wr && (reg_addr == `WSE_OFF_IND_TWO);
    assign wr_scan     = reg_wr && (reg_addr == `WSE_OFF_SCAN_CODE);
    assign wr_pm_one   = reg_wr && (reg_addr == `WSE_OFF_PM_ONE);
    assign wr_pm_two   = reg_wr && (reg_addr == `WSE_OFF_PM_TWO);
    assign wr_smi_sts  = reg_wr && (reg_addr == `WSE_OFF_SMI_STS);
    assign wr_smi_en   = reg_wr && (reg_addr == `WSE_OFF_SMI_EN);
    assign wr_wake_sts = reg_wr && (reg_addr == `WSE_OFF_WAKE_STS);
    assign wr_wake_en  = reg_wr && (reg_addr == `WSE_OFF_WAKE_EN);

    // bit 5 of control two is never stored, only turned into an event
    assign sleep_write = wr_pm_two && reg_wdata[`WSE_BIT_SLEEP];

    // ==========================================================
    // plain control registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ind_mode_reg <= wse_ind_mode_t'(`WSE_RST_IND_TWO);
        end else if (wr_ind) begin
            ind_mode_reg <= wse_ind_mode_t'(reg_wdata[1:0]);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scan_code_reg <= `WSE_RST_BYTE;
        end else if (wr_scan) begin
            scan_code_reg <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pm_one_reg <= `WSE_RST_BYTE;
        end else if (wr_pm_one) begin
            pm_one_reg <= reg_wdata & `WSE_MASK_PM_ONE;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pm_two_reg <= `WSE_RST_BYTE;
        end else if (wr_pm_two) begin
            pm_two_reg <= reg_wdata & `WSE_MASK_PM_TWO;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            smi_en_reg <= `WSE_RST_BYTE;
        end else if (wr_smi_en) begin
            smi_en_reg <= reg_wdata & `WSE_MASK_SMI;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_en_reg <= `WSE_RST_BYTE;
        end else if (wr_wake_en) begin
            wake_en_reg <= reg_wdata & `WSE_MASK_WAKE;
        end
    end

    // ==========================================================
    // SMI status: set wins over a same-cycle clear
    assign smi_set = {general_pin_62, 1'b0, sleep_write, keyboard_port_bit_sixteen,
                      general_pin_37, general_pin_36, general_pin_35,
                      general_pin_34};
    assign smi_clr = wr_smi_sts ? reg_wdata : 8'h00;
    assign smi_sts_next = ((smi_sts_reg & ~smi_clr) | smi_set) & `WSE_MASK_SMI;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            smi_sts_reg <= `WSE_RST_BYTE;
        end else begin
            smi_sts_reg <= smi_sts_next;
        end
    end

    // ==========================================================
    // wake status: recorded whatever the enables say
    assign wake_set = {general_pin_62, 3'b000, general_pin_37, general_pin_36,
                       general_pin_35, general_pin_34};
    // zero bits in the write leave status untouched
    assign wake_clr = wr_wake_sts ? (reg_wdata & `WSE_MASK_WAKE_CLR) : 8'h00;
    assign wake_sts_next = ((wake_sts_reg & ~wake_clr) | wake_set) & `WSE_MASK_WAKE;

    // only the standby reset reaches this register; main-supply resets are
    // kept away so a wake cause survives the host going down
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_sts_reg <= `WSE_RST_BYTE;
        end else begin
            wake_sts_reg <= wake_sts_next;
        end
    end

    // ==========================================================
    // group outputs
    assign smi_group   = |(smi_sts_reg & smi_en_reg);
    assign smi_active  = smi_group && smi_master_enable;
    assign wake_active = |(wake_sts_reg & wake_en_reg) && wake_master_enable;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            smi_group_irq <= 1'b0;
        end else begin
            smi_group_irq <= smi_group;
        end
    end

    // open drain floats when idle, push-pull drives high when idle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            group_smi_output <= 1'b1;
            group_smi_oe_n   <= 1'b1;
        end else if (smi_open_drain) begin
            group_smi_output <= 1'b0;
            group_smi_oe_n   <= ~smi_active;
        end else begin
            group_smi_output <= ~smi_active;
            group_smi_oe_n   <= 1'b0;
        end
    end

    // wake pin is open drain: pulled low only while active
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_output_pin  <= 1'b0;
            wake_output_oe_n <= 1'b1;
        end else begin
            wake_output_pin  <= 1'b0;
            wake_output_oe_n <= ~wake_active;
        end
    end

    // ==========================================================
    // read path, unmapped addresses read zero
    always_comb begin
        rdata_next = 8'h00;
        case (reg_addr)
            `WSE_OFF_IND_TWO:   rdata_next = {6'h00, ind_mode_reg};
            `WSE_OFF_SCAN_CODE: rdata_next = scan_code_reg;
            `WSE_OFF_PM_ONE:    rdata_next = pm_one_reg;
            `WSE_OFF_PM_TWO:    rdata_next = pm_two_reg;
            `WSE_OFF_SMI_STS:   rdata_next = smi_sts_reg;
            `WSE_OFF_SMI_EN:    rdata_next = smi_en_reg;
            `WSE_OFF_WAKE_STS:  rdata_next = wake_sts_reg;
            `WSE_OFF_WAKE_EN:   rdata_next = wake_en_reg;
            default:            rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ==========================================================
    // indicator
    assign blink_if.mode         = ind_mode_reg;
    assign second_indicator_light = blink_if.light_on;

    wse_blinker #(
        .HALF_SEC_CYCLES (HALF_SEC_CYCLES)
    ) u_blinker (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .bif     (blink_if.blink)
    );

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    scan_store_a: assert property (wr_scan |=> scan_code_reg == $past(reg_wdata))
        else $error("scan code not stored");
    pm_one_rd_a: assert property (reg_rd && reg_addr == `WSE_OFF_PM_ONE |=>
        reg_rdata[7:1] == 7'h00)
        else $error("control one upper bits not zero");
    pm_two_rd_a: assert property (reg_rd && reg_addr == `WSE_OFF_PM_TWO |=>
        reg_rdata[7:5] == 3'h0 && reg_rdata[1:0] == 2'h0)
        else $error("control two reserved or write-only bits read non-zero");
    sleep_set_a: assert property (sleep_write |=> smi_sts_reg[`WSE_BIT_SLEEP])
        else $error("sleep write did not set SMI status");
    smi_rsvd_a: assert property (smi_sts_reg[6] == 1'b0 && smi_en_reg[6] == 1'b0)
        else $error("reserved SMI bit set");
    smi_clear_a: assert property (wr_smi_sts && smi_set == 8'h00 |=>
        (smi_sts_reg & $past(reg_wdata)) == 8'h00)
        else $error("SMI status not cleared by write of one");
    smi_group_a: assert property ((smi_sts_reg & smi_en_reg) != 8'h00 |=> smi_group_irq)
        else $error("enabled SMI status did not raise group");
    smi_idle_a: assert property (!smi_master_enable |=>
        group_smi_oe_n || group_smi_output)
        else $error("SMI pin active without master enable");
    wake_rec_a: assert property (general_pin_34 ##1 !wr_wake_sts |=> wake_sts_reg[0])
        else $error("wake event not recorded");
    wake_hold_a: assert property (wake_sts_reg[7] && !wr_wake_sts |=> wake_sts_reg[7])
        else $error("wake status lost without clear");
    wake_gate_a: assert property (wake_en_reg == 8'h00 |=> wake_output_oe_n)
        else $error("wake pin driven with no enable");
    wake_zero_a: assert property (wr_wake_sts && reg_wdata == 8'h00 |=>
        (wake_sts_reg & $past(wake_sts_reg)) == $past(wake_sts_reg))
        else $error("zero write changed wake status");

    // ==========================================================
    // checks on stored and reserved bits
    ind_wr_a: assert property (wr_ind |=>
        ind_mode_reg == $past(reg_wdata[1:0]))
        else $error("indicator code not stored");
    ind_rd_a: assert property (reg_rd && reg_addr == `WSE_OFF_IND_TWO |=>
        reg_rdata[7:2] == 6'h00)
        else $error("indicator reserved bits read non-zero");
    scan_rd_a: assert property (reg_rd && reg_addr == `WSE_OFF_SCAN_CODE |=>
        reg_rdata == $past(scan_code_reg))
        else $error("scan code read back wrong");
    smi_rd_a: assert property (reg_rd && reg_addr == `WSE_OFF_SMI_STS |=>
        reg_rdata[6] == 1'b0)
        else $error("reserved SMI status bit read non-zero");
    pm_one_hold_a: assert property (pm_one_reg[7:1] == 7'h00)
        else $error("control one upper bits stored");
    pm_two_wr_a: assert property (wr_pm_two |=>
        pm_two_reg[4:2] == $past(reg_wdata[4:2]))
        else $error("control two storage bits not written");
    pm_two_bit5_a: assert property (pm_two_reg[`WSE_BIT_SLEEP] == 1'b0)
        else $error("write-only bit 5 stored");
    wake_en_wr_a: assert property (wr_wake_en |=>
        wake_en_reg == ($past(reg_wdata) & `WSE_MASK_WAKE))
        else $error("wake enable not stored");
    wake_rsvd_a: assert property (((wake_sts_reg | wake_en_reg)
        & ~`WSE_MASK_WAKE) == 8'h00)
        else $error("reserved wake bit set");

    // ==========================================================
    // checks on event capture
    smi_src_a: assert property (keyboard_port_bit_sixteen |=> smi_sts_reg[4])
        else $error("keyboard event not recorded");
    pin62_rec_a: assert property (general_pin_62 |=>
        smi_sts_reg[7] && wake_sts_reg[7])
        else $error("pin 62 event not recorded");
    smi_hold_a: assert property (smi_sts_reg[0] && !wr_smi_sts |=> smi_sts_reg[0])
        else $error("SMI status lost without clear");
    wake_keep_a: assert property (wake_sts_reg[0] && !wr_wake_sts |=> wake_sts_reg[0])
        else $error("wake status bit 0 lost without clear");
    // a source still high sets its bit again, so the clear check waits for it to drop
    wake_clr_a: assert property (wr_wake_sts && reg_wdata[0] && !general_pin_34 |=>
        !wake_sts_reg[0])
        else $error("wake status not cleared by write of one");

    // ==========================================================
    // checks on pins and interrupt
    smi_quiet_a: assert property ((smi_sts_reg & smi_en_reg) == 8'h00 |=>
        !smi_group_irq)
        else $error("group raised with no enabled status");
    smi_pp_a: assert property (!smi_open_drain && !smi_active |=>
        group_smi_output && !group_smi_oe_n)
        else $error("push-pull SMI pin not high when idle");
    smi_od_a: assert property (smi_open_drain && !smi_active |=> group_smi_oe_n)
        else $error("open-drain SMI pin driven when idle");
    wake_drive_a: assert property (wake_active |=>
        !wake_output_oe_n && !wake_output_pin)
        else $error("wake pin not pulled low when active");
    wake_master_a: assert property (!wake_master_enable |=> wake_output_oe_n)
        else $error("wake pin driven with master enable off");

    wake_clr_c:  cover property (wr_wake_sts && wake_sts_reg != 8'h00);
    sleep_evt_c: cover property (sleep_write ##1 smi_sts_reg[`WSE_BIT_SLEEP]);
    smi_pin_c:   cover property (smi_active ##1 !group_smi_oe_n && !group_smi_output);
    wake_pin_c:  cover property (wake_active ##1 !wake_output_oe_n);
endmodule

// *** tb.sv ***
// Purpose : self-checking bench for the group-seven wake/SMI event block
// Assumes : half-second time base shortened to 8 cycles, 40 MHz ref_clk
// Notes   : register rows first, then events, pins, blinker and reset
`timescale 1ns/1ps
`include "wse_defs.svh"

module tb;
    import wse_pkg::*;

    // ==========================================================
    // signals
    localparam int unsigned HALF = 8;
    typedef struct {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rexp;
    } wse_tb_row_t;

    logic       ref_clk;
    logic       rst_n;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic [5:0] src;
    logic       smi_master_enable;
    logic       smi_open_drain;
    logic       wake_master_enable;
    logic       group_smi_output;
    logic       group_smi_oe_n;
    logic       wake_output_pin;
    logic       wake_output_oe_n;
    logic       smi_group_irq;
    logic       light;
    logic [7:0] rd;
    int         errors;
    int         comparisons;
    int         cnt;

    // the last row is an unmapped address
    wse_tb_row_t rows [8] = '{
        '{8'h5E, 8'hFF, 8'h03}, '{8'h5F, 8'h01, 8'h01}, '{8'h5F, 8'h80, 8'h80},
        '{8'h60, 8'hFF, 8'h01}, '{8'h61, 8'hFF, 8'h1C}, '{8'h66, 8'hFF, 8'hBF},
        '{8'h6C, 8'hFF, 8'h8F}, '{8'h70, 8'hFF, 8'h00}};
    // source order: pins 34..37, keyboard bit, pin 62
    logic [7:0] smi_bit  [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h80};
    logic [7:0] wake_bit [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h00, 8'h80};
    logic [7:0] all_addr [8] = '{8'h5E, 8'h5F, 8'h60, 8'h61, 8'h64, 8'h66, 8'h68, 8'h6C};
    int         lit_exp  [4] = '{0, 32, 16, 64};

    wse_event_regs #(.HALF_SEC_CYCLES(HALF)) wse_event_regs_i (
        .ref_clk                   (ref_clk),
        .rst_n                     (rst_n),
        .reg_addr                  (reg_addr),
        .reg_wdata                 (reg_wdata),
        .reg_wr                    (reg_wr),
        .reg_rd                    (reg_rd),
        .reg_rdata                 (reg_rdata),
        .general_pin_34            (src[0]),
        .general_pin_35            (src[1]),
        .general_pin_36            (src[2]),
        .general_pin_37            (src[3]),
        .general_pin_62            (src[5]),
        .keyboard_port_bit_sixteen (src[4]),
        .smi_master_enable         (smi_master_enable),
        .smi_open_drain            (smi_open_drain),
        .wake_master_enable        (wake_master_enable),
        .group_smi_output          (group_smi_output),
        .group_smi_oe_n            (group_smi_oe_n),
        .wake_output_pin           (wake_output_pin),
        .wake_output_oe_n          (wake_output_oe_n),
        .smi_group_irq             (smi_group_irq),
        .second_indicator_light    (light)
    );

    // ==========================================================
    // clock and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // every wait below is a fixed count, so this only trips on a stuck run
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        print_verdict();
    end

    // ==========================================================
    // tasks
    task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check1(input string name, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe edge
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic pulse(input int i);
        @(posedge ref_clk);
        src[i] <= 1'b1;
        @(posedge ref_clk);
        src[i] <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic print_verdict();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        errors = 0; comparisons = 0;
        rst_n = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
        src = 6'h00; smi_master_enable = 1'b1; smi_open_drain = 1'b1; wake_master_enable = 1'b1;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            reg_write(rows[i].addr, rows[i].wdata);
            reg_read(rows[i].addr, rd);
            check8("row readback", rows[i].rexp, rd);
        end
        reg_read(8'h64, rd);
        check8("sleep smi status", 8'h20, rd);
        check1("irq on sleep", 1'b1, smi_group_irq);
        reg_write(8'h64, 8'h20);
        repeat (3) @(posedge ref_clk);
        reg_read(8'h64, rd);
        check8("smi status cleared", 8'h00, rd);
        check1("irq after clear", 1'b0, smi_group_irq);
        reg_write(8'h66, 8'h00);
        for (int i = 0; i < 6; i++) begin
            pulse(i);
            reg_read(8'h64, rd);
            check8("smi status source", smi_bit[i], rd);
            reg_read(8'h68, rd);
            check8("wake status source", wake_bit[i], rd);
            check1("irq disabled source", 1'b0, smi_group_irq);
            check1("wake oe_n", wake_bit[i] == 8'h00, wake_output_oe_n);
            reg_write(8'h64, 8'hFF);
            reg_write(8'h68, 8'hFF);
            repeat (2) @(posedge ref_clk);
            reg_read(8'h64, rd);
            check8("smi status clear all", 8'h00, rd);
            reg_read(8'h68, rd);
            check8("wake status clear all", 8'h00, rd);
        end
        // a disabled wake source still shows in status but leaves the pin idle
        reg_write(8'h6C, 8'h00);
        pulse(1);
        reg_read(8'h68, rd);
        check8("wake status disabled", 8'h02, rd);
        check1("wake pin idle", 1'b1, wake_output_oe_n);
        reg_write(8'h68, 8'h00);
        reg_read(8'h68, rd);
        check8("wake write zero", 8'h02, rd);
        // enabled source drives the pin low, the master enable still gates it
        reg_write(8'h6C, 8'h02);
        repeat (2) @(posedge ref_clk);
        check1("wake oe_n enabled", 1'b0, wake_output_oe_n);
        check1("wake pin level", 1'b0, wake_output_pin);
        wake_master_enable <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check1("wake oe_n master off", 1'b1, wake_output_oe_n);
        wake_master_enable <= 1'b1;
        reg_write(8'h68, 8'h02);
        reg_read(8'h68, rd);
        check8("wake write one", 8'h00, rd);
        // smi pin in both buffer types, with master enable on and off
        reg_write(8'h66, 8'h01);
        pulse(0);
        check1("irq enabled source", 1'b1, smi_group_irq);
        for (int k = 0; k < 4; k++) begin
            @(posedge ref_clk);
            smi_open_drain    <= k[0];
            smi_master_enable <= k[1];
            repeat (3) @(posedge ref_clk);
            check1("smi oe_n", k[0] ? !k[1] : 1'b0, group_smi_oe_n);
            if (k[1] || !k[0])
                check1("smi out", k[0] ? 1'b0 : !k[1], group_smi_output);
        end
        // whole frames of four half-second phases make the lit count phase-free
        for (int m = 0; m < 4; m++) begin
            reg_write(8'h5E, 8'(m));
            repeat (2) @(posedge ref_clk);
            cnt = 0;
            repeat (8 * HALF) begin
                @(posedge ref_clk);
                #1;
                if (light === 1'b1)
                    cnt++;
            end
            check8("lit cycles", 8'(lit_exp[m]), 8'(cnt));
        end
        // standby reset in mid-run initialises every register
        reg_write(8'h5F, 8'h5A);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        check1("smi oe_n in reset", 1'b1, group_smi_oe_n);
        check1("wake oe_n in reset", 1'b1, wake_output_oe_n);
        rst_n <= 1'b1;
        foreach (all_addr[i]) begin
            reg_read(all_addr[i], rd);
            check8("reset value", all_addr[i] == 8'h5E ? 8'h01 : 8'h00, rd);
        end
        print_verdict();
    end
endmodule
